// ---- hw/rst_top.sv ----
// Operation
// - four sources each raise system reset
// - watchdog during stabilisation selects ring oscillator
// - cause writes need protected key sequence
// - cause register byte and bit accessible
// - reset pin clears all cause flags
// - flags: watchdog bit4, clock loss bit1, undervolt bit0
// - internal reset sets only its own flag
// - writing zero clears a flag
// - setting beats a simultaneous clear
// - bits 7,6,5,3,2 read zero
// - pin low holds reset, rising starts stabilisation before release
// - internal reset holds fixed time, oscillator off
`timescale 1ns/100ps
`default_nettype none
module rst_top
	import rst_pkg::*;
#(
	parameter int HOLD_CYCLES = HOLD_CYCLES_DEF,
	parameter int STAB_CYCLES = STAB_CYCLES_DEF
)
(
	input wire logic SYS_CLK, // 10 MHz system clock
	input wire logic RST_N, // synchronous block reset, active low
	input wire logic RESET_PIN_N, // external reset pin, active low
	input wire logic WDT_OVF, // watchdog overflow, same clock
	input wire logic LVD_DETECT, // low-voltage detector, asynchronous
	input wire logic CLK_LOSS, // clock-loss monitor, asynchronous
	input wire logic [31:0] AVS_ADDRESS, // byte address
	input wire logic AVS_READ, // read request
	input wire logic AVS_WRITE, // write request
	input wire logic [31:0] AVS_WRITEDATA, // write data
	input wire logic [3:0] AVS_BYTEENABLE, // byte lanes
	output logic [31:0] AVS_READDATA, // read data
	output logic AVS_WAITREQUEST, // high until answered
	output logic SYS_RESET_N, // system reset, active low
	output logic MAIN_OSC_EN, // main oscillator enable
	output logic RING_OSC_SEL, // cpu runs from ring oscillator
	output logic IRQ // level interrupt
);
	typedef struct packed
	{
		rst_phase_type phase;
		logic [CNT_W-1:0] cnt;
		logic [7:0] cause;
		logic ring;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_mask;
		logic wait_req;
		logic [31:0] rdata;
		logic sys_rst_n;
		logic osc_en;
		logic irq;
	} rst_top_regs_type;

	localparam rst_top_regs_type RESET_STATE = '{
		phase: PH_PIN,
		cnt: '0,
		cause: CAUSE_RESET,
		ring: 1'b0,
		irq_stat: '0,
		irq_mask: IRQ_MASK_RESET,
		wait_req: 1'b1,
		rdata: '0,
		sys_rst_n: 1'b0,
		osc_en: 1'b0,
		irq: 1'b0
	};
	localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYCLES - 1);
	localparam logic [CNT_W-1:0] STAB_LAST = CNT_W'(STAB_CYCLES - 1);

	if (HOLD_CYCLES < 1 || HOLD_CYCLES >= (1 << CNT_W) || STAB_CYCLES < 1 || STAB_CYCLES >= (1 << CNT_W))
	begin : g_chk
		$error("rst_top: HOLD_CYCLES and STAB_CYCLES must be 1 to 65535");
	end

	rst_top_regs_type s_reg;
	rst_top_regs_type s_next;

	logic pin_s;
	logic lvd_s;
	logic clm_s;
	logic req;
	logic wr;
	logic rd;
	logic hit_cause;
	logic hit_cmd;
	logic hit_stat;
	logic hit_mask;
	logic hit_status;
	logic lvd_trig;
	logic clm_trig;
	logic wdt_trig;
	logic [7:0] set_vec;
	logic any_set;
	logic ev_emerg;
	logic ev_release;
	logic [IRQ_W-1:0] ev;

	rst_prot_if prot_bus();

	// pin and analog detectors come from outside the clock domain
	rst_sync #(
		.WIDTH(3),
		.RESET_VAL(3'h0)
	) rst_sync_i (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.din({CLK_LOSS, LVD_DETECT, RESET_PIN_N}),
		.dout({clm_s, lvd_s, pin_s})
	);

	rst_protect rst_protect_i (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.p(prot_bus.prot)
	);

	// one answer per request; wait_req low for exactly one cycle
	assign req = (AVS_READ || AVS_WRITE) && s_reg.wait_req;
	// only lane 0 carries register data; writes without it are dropped
	assign wr = req && AVS_WRITE && AVS_BYTEENABLE[0];
	assign rd = req && AVS_READ;
	assign hit_cause = (AVS_ADDRESS == ADDR_CAUSE);
	assign hit_cmd = (AVS_ADDRESS == ADDR_PROT_CMD);
	assign hit_stat = (AVS_ADDRESS == ADDR_IRQ_STAT);
	assign hit_mask = (AVS_ADDRESS == ADDR_IRQ_MASK);
	assign hit_status = (AVS_ADDRESS == ADDR_STATUS);

	assign prot_bus.wr_any = wr;
	assign prot_bus.wr_key = wr && hit_cmd && (AVS_WRITEDATA[7:0] == PROT_KEY);
	assign prot_bus.wr_cause = wr && hit_cause;

	// detectors are ignored while the pin already holds reset
	assign lvd_trig = lvd_s && (s_reg.phase != PH_PIN);
	assign clm_trig = clm_s && (s_reg.phase != PH_PIN);
	// watchdog is stopped in hold; in stabilisation it means a bad crystal
	assign wdt_trig = WDT_OVF && (s_reg.phase == PH_RUN);
	assign set_vec = ({8{lvd_trig}} & MASK_UNDERVOLT) | ({8{clm_trig}} & MASK_CLK_LOSS) | ({8{wdt_trig}} & MASK_WDT);
	assign any_set = |set_vec;

	assign ev_emerg = (s_reg.phase == PH_STAB) && WDT_OVF && !any_set && pin_s;
	assign ev_release = (s_reg.phase == PH_STAB) && !WDT_OVF && (s_reg.cnt == STAB_LAST) && !any_set && pin_s;
	assign ev = ({IRQ_W{ev_emerg}} & IRQ_EMERG) | ({IRQ_W{prot_bus.violation}} & IRQ_PROT_ERR)
		| ({IRQ_W{ev_release}} & IRQ_RELEASE);

	always_comb
	begin
		s_next = s_reg;

		case (s_reg.phase)
			PH_PIN:
			begin
				if (pin_s)
				begin
					s_next.phase = PH_STAB;
					s_next.cnt = '0;
				end
			end
			PH_HOLD:
			begin
				if (s_reg.cnt == HOLD_LAST)
				begin
					s_next.phase = PH_STAB;
					s_next.cnt = '0;
				end
				else
					s_next.cnt = s_reg.cnt + 1'b1;
			end
			PH_STAB:
			begin
				if (WDT_OVF)
				begin
					s_next.ring = 1'b1;
					s_next.phase = PH_RUN;
				end
				else if (s_reg.cnt == STAB_LAST)
					s_next.phase = PH_RUN;
				else
					s_next.cnt = s_reg.cnt + 1'b1;
			end
			PH_RUN:
			begin
				s_next.cnt = '0;
			end
			default:
			begin
				s_next.phase = PH_PIN;
			end
		endcase

		// a new internal source restarts the hold
		if (any_set)
		begin
			s_next.phase = PH_HOLD;
			s_next.cnt = '0;
			s_next.ring = 1'b0;
		end
		if (!pin_s)
		begin
			s_next.phase = PH_PIN;
			s_next.cnt = '0;
			s_next.ring = 1'b0;
		end

		// flags are untouched by the internal reset itself
		if (prot_bus.permit)
			s_next.cause = s_reg.cause & AVS_WRITEDATA[7:0];
		s_next.cause = (s_next.cause | set_vec) & CAUSE_USED;
		if (!pin_s)
			s_next.cause = CAUSE_RESET;

		if (wr && hit_stat)
			s_next.irq_stat = s_reg.irq_stat & ~AVS_WRITEDATA[IRQ_W-1:0];
		s_next.irq_stat = s_next.irq_stat | ev;
		if (wr && hit_mask)
			s_next.irq_mask = AVS_WRITEDATA[IRQ_W-1:0];

		s_next.wait_req = !req;
		s_next.rdata = '0;
		if (rd)
		begin
			if (hit_cause)
				s_next.rdata = {24'h0, s_reg.cause & CAUSE_USED};
			else if (hit_stat)
				s_next.rdata = {29'h0, s_reg.irq_stat};
			else if (hit_mask)
				s_next.rdata = {29'h0, s_reg.irq_mask};
			// run bit follows the next phase, so it matches SYS_RESET_N while the data stands
			else if (hit_status)
				s_next.rdata = {29'h0, s_reg.ring, s_next.phase == PH_RUN, s_reg.phase == PH_STAB};
		end

		// outputs follow the next phase so they line up with it
		s_next.sys_rst_n = (s_next.phase == PH_RUN);
		s_next.osc_en = (s_next.phase == PH_STAB) || (s_next.phase == PH_RUN);
		s_next.irq = |(s_next.irq_stat & s_next.irq_mask);
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (!RST_N)
			s_reg <= RESET_STATE;
		else
			s_reg <= s_next;
	end

	assign AVS_READDATA = s_reg.rdata;
	assign AVS_WAITREQUEST = s_reg.wait_req;
	assign SYS_RESET_N = s_reg.sys_rst_n;
	assign MAIN_OSC_EN = s_reg.osc_en;
	assign RING_OSC_SEL = s_reg.ring;
	assign IRQ = s_reg.irq;

	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RST_N);

	sequence s_hold_done;
		(s_reg.phase == PH_HOLD) && (s_reg.cnt == HOLD_LAST) && !any_set && pin_s;
	endsequence
	sequence s_cause_read;
		rd && hit_cause;
	endsequence
	sequence s_answer;
		!AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
	endsequence

	src_reset_a: assert property ((any_set && pin_s) |=> !SYS_RESET_N && (s_reg.phase == PH_HOLD))
		else $error("internal source did not raise reset");
	emerg_mode_a: assert property (ev_emerg |=> RING_OSC_SEL && SYS_RESET_N && MAIN_OSC_EN)
		else $error("emergency mode not entered");
	clear_only_a: assert property ((prot_bus.permit && !any_set && pin_s)
		|=> s_reg.cause == ($past(s_reg.cause) & $past(AVS_WRITEDATA[7:0])))
		else $error("cause write did not clear as written");
	pin_clear_a: assert property (!pin_s |=> s_reg.cause == CAUSE_RESET && !SYS_RESET_N && !MAIN_OSC_EN)
		else $error("pin reset did not clear flags");
	own_flag_a: assert property ((wdt_trig && pin_s && !prot_bus.permit)
		|=> (s_reg.cause == ($past(s_reg.cause) | $past(set_vec))) && ((s_reg.cause & MASK_WDT) != 8'h00))
		else $error("watchdog flag wrong");
	set_wins_a: assert property ((prot_bus.permit && any_set && pin_s)
		|=> (s_reg.cause & $past(set_vec)) == $past(set_vec))
		else $error("clear beat a set");
	rsvd_read_a: assert property (s_cause_read |=> ((AVS_READDATA[7:0] & ~CAUSE_USED) == 8'h00) and s_answer)
		else $error("reserved cause bits read nonzero");
	hold_osc_a: assert property ((s_reg.phase == PH_HOLD) |-> !MAIN_OSC_EN && !SYS_RESET_N)
		else $error("oscillator running during hold");
	hold_end_a: assert property (s_hold_done |=> (s_reg.phase == PH_STAB) && MAIN_OSC_EN && !SYS_RESET_N)
		else $error("hold did not end on time");
	keep_flags_a: assert property (((s_reg.phase == PH_HOLD) && pin_s && !any_set && !prot_bus.permit)
		|=> $stable(s_reg.cause))
		else $error("flags lost during hold");
	bus_answer_a: assert property (req |=> s_answer)
		else $error("bus request not answered in one cycle");

	sequence s_pin_rise;
		(s_reg.phase == PH_PIN) && pin_s;
	endsequence
	pin_release_a: assert property (s_pin_rise |=> (s_reg.phase == PH_STAB) && MAIN_OSC_EN && !SYS_RESET_N)
		else $error("pin release did not start stabilisation");
	stab_release_a: assert property (ev_release |=> SYS_RESET_N && MAIN_OSC_EN && !RING_OSC_SEL)
		else $error("reset not released after stabilisation");
endmodule : rst_top
`default_nettype wire

// ---- hw/rst_pkg.sv ----
`default_nettype none
package rst_pkg;
	// byte addresses on the register bus
	localparam logic [31:0] ADDR_CAUSE = 32'hfffff888;
	localparam logic [31:0] ADDR_PROT_CMD = 32'hfffff884;
	localparam logic [31:0] ADDR_IRQ_STAT = 32'hfffff88c;
	localparam logic [31:0] ADDR_IRQ_MASK = 32'hfffff890;
	localparam logic [31:0] ADDR_STATUS = 32'hfffff894;
	localparam logic [7:0] PROT_KEY = 8'ha5;
	// cause register layout
	localparam logic [7:0] MASK_UNDERVOLT = 8'h01;
	localparam logic [7:0] MASK_CLK_LOSS = 8'h02;
	localparam logic [7:0] MASK_WDT = 8'h10;
	localparam logic [7:0] CAUSE_USED = 8'h13;
	localparam logic [7:0] CAUSE_RESET = 8'h00;
	// interrupt status / mask layout
	localparam int IRQ_W = 3;
	localparam logic [2:0] IRQ_EMERG = 3'h1;
	localparam logic [2:0] IRQ_PROT_ERR = 3'h2;
	localparam logic [2:0] IRQ_RELEASE = 3'h4;
	localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
	// timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int HOLD_TIME_NS = 1000;
	localparam int HOLD_CYCLES_DEF = (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STAB_TIME_NS = 204800;
	localparam int STAB_CYCLES_DEF = (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 16;
	typedef enum logic [1:0] {PH_PIN, PH_HOLD, PH_STAB, PH_RUN} rst_phase_type;
endpackage : rst_pkg
`default_nettype wire

// ---- hw/rst_prot_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface rst_prot_if;
	logic wr_any;
	logic wr_key;
	logic wr_cause;
	logic permit;
	logic violation;
	modport ctl (output wr_any, wr_key, wr_cause, input permit, violation);
	modport prot (input wr_any, wr_key, wr_cause, output permit, violation);
endinterface : rst_prot_if
`default_nettype wire

// ---- hw/rst_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
module rst_sync
	import rst_pkg::*;
#(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
	input wire logic clk, // system clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic [WIDTH-1:0] din, // asynchronous inputs
	output logic [WIDTH-1:0] dout // synchronised copy
);
	typedef struct packed
	{
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
	} rst_sync_regs_type;

	rst_sync_regs_type s_reg;
	rst_sync_regs_type s_next;

	if (WIDTH < 1)
	begin : g_chk
		$error("rst_sync: WIDTH must be at least 1");
	end

	// meta is read by sync only
	always_comb
	begin
		s_next.meta = din;
		s_next.sync = s_reg.meta;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			s_reg <= '{meta: RESET_VAL, sync: RESET_VAL};
		else
			s_reg <= s_next;
	end

	assign dout = s_reg.sync;
endmodule : rst_sync
`default_nettype wire

// ---- hw/rst_protect.sv ----
`timescale 1ns/100ps
`default_nettype none
module rst_protect
	import rst_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic rst_n, // synchronous reset, active low
	rst_prot_if.prot p // write strobes and verdict
);
	typedef struct packed
	{
		logic armed;
	} rst_prot_regs_type;

	rst_prot_regs_type s_reg;
	rst_prot_regs_type s_next;

	// any write other than the key disarms, so the key must be the write just before
	always_comb
	begin
		s_next = s_reg;
		if (p.wr_any)
			s_next.armed = p.wr_key;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign p.permit = p.wr_cause && s_reg.armed;
	assign p.violation = p.wr_cause && !s_reg.armed;

	no_key_deny_a: assert property (@(posedge clk) disable iff (!rst_n)
		(p.wr_any && !p.wr_key) |=> (p.wr_cause |-> !p.permit))
		else $error("cause write allowed without key");
	key_grant_a: assert property (@(posedge clk) disable iff (!rst_n)
		(p.wr_key ##1 p.wr_cause) |-> p.permit)
		else $error("cause write refused after key");
endmodule : rst_protect
`default_nettype wire

// ---- dv/rst_top_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module rst_top_tb
	import rst_pkg::*;
;
	// short counts keep the run brief
	localparam int HC = 3;
	localparam int SC = 4;
	logic sys_clk, rst_n, pin_n, wdt, lvd, closs, rd, wr;
	logic [31:0] addr, wdat, rdat, q;
	logic [3:0] be;
	logic waitreq, sys_rst_n, osc_en, ring, irq;
	int miscompares = 0;
	int n_compared = 0;
	int cyc = 0;

	rst_top #(.HOLD_CYCLES(HC), .STAB_CYCLES(SC)) rst_top_i (.SYS_CLK(sys_clk), .RST_N(rst_n),
		.RESET_PIN_N(pin_n), .WDT_OVF(wdt), .LVD_DETECT(lvd), .CLK_LOSS(closs),
		.AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat),
		.AVS_BYTEENABLE(be), .AVS_READDATA(rdat), .AVS_WAITREQUEST(waitreq),
		.SYS_RESET_N(sys_rst_n), .MAIN_OSC_EN(osc_en), .RING_OSC_SEL(ring), .IRQ(irq));

	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	task automatic tally_and_finish();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish

	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			miscompares++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick

	// one access; request held until waitrequest is seen low
	task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d);
		addr <= a;
		wr <= w;
		rd <= !w;
		wdat <= {24'h0, d};
		// the answer ends this wait, or else the bench timeout
		do
			@(posedge sys_clk);
		while (waitreq !== 1'b0);
		q = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge sys_clk);
	endtask : bus

	task automatic prot_wr(input logic [7:0] d);
		bus(1'b1, ADDR_PROT_CMD, PROT_KEY);
		bus(1'b1, ADDR_CAUSE, d);
	endtask : prot_wr

	task automatic wait_run();
		while (sys_rst_n !== 1'b1)
			@(posedge sys_clk);
	endtask : wait_run

	task automatic pin_scn();
		pin_n <= 1'b0;
		tick(4);
		chk(sys_rst_n, 0);
		bus(1'b0, ADDR_CAUSE, 8'h00);
		chk(q, CAUSE_RESET);
		pin_n <= 1'b1;
		wait_run();
		chk(sys_rst_n, 1);
	endtask : pin_scn

	// hold lasts HC cycles, then stabilisation SC cycles before release
	task automatic wdt_scn();
		wdt <= 1'b1;
		tick(1);
		wdt <= 1'b0;
		tick(1);
		chk(sys_rst_n, 0);
		chk(osc_en, 0);
		tick(HC - 1);
		chk(osc_en, 0);
		tick(1);
		chk(osc_en, 1);
		tick(SC - 1);
		chk(sys_rst_n, 0);
		tick(1);
		chk(sys_rst_n, 1);
		wait_run();
		bus(1'b0, ADDR_CAUSE, 8'h00);
		chk(q, MASK_WDT);
	endtask : wdt_scn

	// detector level held a few cycles, then dropped
	task automatic src_scn(input logic l, input logic c, input logic [7:0] exp);
		lvd <= l;
		closs <= c;
		tick(3);
		lvd <= 1'b0;
		closs <= 1'b0;
		tick(3);
		chk(sys_rst_n, 0);
		wait_run();
		bus(1'b0, ADDR_CAUSE, 8'h00);
		chk(q, exp);
	endtask : src_scn

	task automatic write_scn();
		bus(1'b1, ADDR_CAUSE, 8'h00);
		bus(1'b0, ADDR_CAUSE, 8'h00);
		chk(q, CAUSE_USED);
		bus(1'b1, ADDR_PROT_CMD, PROT_KEY);
		be <= 4'h0;
		bus(1'b1, ADDR_CAUSE, 8'h00);
		be <= 4'h1;
		bus(1'b0, ADDR_CAUSE, 8'h00);
		chk(q, CAUSE_USED);
		bus(1'b0, ADDR_IRQ_STAT, 8'h00);
		chk(q & 32'h2, 32'h2);
		prot_wr(8'hfe);
		bus(1'b0, ADDR_CAUSE, 8'h00);
		chk(q, 32'h12);
		prot_wr(8'hff);
		bus(1'b0, ADDR_CAUSE, 8'h00);
		chk(q, 32'h12);
		prot_wr(8'hec);
		bus(1'b0, ADDR_CAUSE, 8'h00);
		chk(q, 32'h00);
		prot_wr(8'hff);
		bus(1'b0, ADDR_CAUSE, 8'h00);
		chk(q, 32'h00);
		bus(1'b0, 32'hfffff8a0, 8'h00);
		chk(q, 32'h00);
	endtask : write_scn

	task automatic irq_scn();
		chk(irq, 0);
		bus(1'b1, ADDR_IRQ_MASK, 8'h02);
		tick(1);
		chk(irq, 1);
		bus(1'b1, ADDR_IRQ_STAT, 8'h02);
		tick(1);
		chk(irq, 0);
		bus(1'b1, ADDR_IRQ_MASK, 8'h00);
	endtask : irq_scn

	task automatic emerg_scn();
		int n;
		n = 0;
		pin_n <= 1'b0;
		tick(4);
		pin_n <= 1'b1;
		while (osc_en !== 1'b1 && n < 20)
		begin
			@(posedge sys_clk);
			n++;
		end
		wdt <= 1'b1;
		tick(1);
		wdt <= 1'b0;
		tick(2);
		chk(ring, 1);
		chk(sys_rst_n, 1);
		bus(1'b0, ADDR_STATUS, 8'h00);
		chk(q, 32'h6);
		bus(1'b0, ADDR_IRQ_STAT, 8'h00);
		chk(q, 32'h5);
		bus(1'b0, ADDR_CAUSE, 8'h00);
		chk(q, 32'h00);
	endtask : emerg_scn

	// clear write and watchdog set land on one edge
	task automatic coinc_scn();
		bus(1'b1, ADDR_PROT_CMD, PROT_KEY);
		fork
			bus(1'b1, ADDR_CAUSE, 8'h00);
			begin
				wdt <= 1'b1;
				tick(1);
				wdt <= 1'b0;
			end
		join
		wait_run();
		bus(1'b0, ADDR_CAUSE, 8'h00);
		chk(q, MASK_WDT);
	endtask : coinc_scn

	initial
	begin
		rst_n = 1'b0;
		pin_n = 1'b0;
		{wdt, lvd, closs, rd, wr} = 5'h00;
		addr = 32'h0;
		wdat = 32'h0;
		be = 4'h1;
		// synchronisers take their reset value, so two edges suffice
		tick(2);
		rst_n <= 1'b1;
		tick(1);
		pin_scn();
		wdt_scn();
		src_scn(1'b1, 1'b0, 8'h11);
		src_scn(1'b0, 1'b1, 8'h13);
		write_scn();
		irq_scn();
		emerg_scn();
		coinc_scn();
		tally_and_finish();
	end
endmodule : rst_top_tb
`default_nettype wire
